//--- bench/data_io_space.sv
// data memory and I/O space model facing the execution unit
`timescale 1ns/1ps
module data_io_space #(
  parameter int IO_AW = 6
) (
  input logic mclk,
  input logic [15:0] mem_addr,
  input logic mem_re,
  input logic mem_we,
  input logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  input logic [IO_AW-1:0] io_addr,
  input logic io_re,
  input logic io_we,
  input logic [7:0] io_wdata,
  output logic [7:0] io_rdata
);
  // ----------------------------------------------------------------
  // storage and read paths
  // ----------------------------------------------------------------
  logic [7:0] mem [0:65535];
  logic [7:0] io [0:(1<<IO_AW)-1];
  logic [7:0] last_m_q = 8'h00;
  logic [7:0] last_i_q = 8'h00;

  // unselected reads show the inverse of the last byte, never a stale copy
  assign mem_rdata = mem_re ? mem[mem_addr] : ~last_m_q;
  assign io_rdata = io_re ? io[io_addr] : ~last_i_q;

  always @(posedge mclk) begin
    if (mem_we) mem[mem_addr] <= mem_wdata;
    if (io_we) io[io_addr] <= io_wdata;
    if (mem_re) last_m_q <= mem[mem_addr];
    if (io_re) last_i_q <= io[io_addr];
  end
endmodule

//--- bench/test_bit_flag_transfer_exec.sv
// self-checking bench for the flag and transfer execution unit
`timescale 1ns/1ps
module test_bit_flag_transfer_exec;
  import exec_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  exec_op_t op_code = idle_op;
  logic [3:0] op_rd = 4'h0;
  logic [3:0] op_rr = 4'h0;
  logic [2:0] op_bit = 3'h0;
  logic [7:0] op_imm = 8'h00;
  logic [15:0] op_addr = 16'h0000;
  ptr_sel_t op_ptr = ptr_x;
  ptr_mode_t op_mode = ptr_plain;
  logic [3:0] dbg_idx = 4'h0;
  logic op_ready, mem_re, mem_we, io_re, io_we;
  logic break_pulse, sleep_pulse, wdr_pulse;
  logic [15:0] mem_addr, stack_ptr;
  logic [7:0] mem_wdata, mem_rdata, io_wdata, io_rdata;
  logic [7:0] status_register, dbg_data;
  logic [IO_AW_DEF-1:0] io_addr;
  int num_errors = 0;
  int num_checks = 0;
  int busy;
  logic [7:0] pulses;
  logic [7:0] sr;

  bit_flag_transfer_exec dut_u (
    .mclk, .rst, .op_valid, .op_ready, .op_code, .op_rd, .op_rr, .op_bit,
    .op_imm, .op_addr, .op_ptr, .op_mode, .mem_addr, .mem_re, .mem_we,
    .mem_wdata, .mem_rdata, .io_addr, .io_re, .io_we, .io_wdata,
    .io_rdata, .status_register, .stack_ptr, .break_pulse, .sleep_pulse,
    .wdr_pulse, .dbg_idx, .dbg_data
  );

  data_io_space #(.IO_AW(IO_AW_DEF)) mem_u (
    .mclk, .mem_addr, .mem_re, .mem_we, .mem_wdata, .mem_rdata,
    .io_addr, .io_re, .io_we, .io_wdata, .io_rdata
  );

  always #2.5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp16({8'h00, got}, {8'h00, exp});
  endtask

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // offer one op, hold it until taken, then count the busy cycles
  task automatic run(input exec_op_t c, input logic [3:0] rd = 4'h0,
      input logic [3:0] rr = 4'h0, input ptr_sel_t p = ptr_x,
      input ptr_mode_t m = ptr_plain, input logic [2:0] b = 3'h0,
      input logic [7:0] k = 8'h00, input logic [15:0] a = 16'h0000);
    int n;
    n = 0;
    @(posedge mclk);
    op_valid <= 1'b1;
    op_code <= c;
    op_rd <= rd;
    op_rr <= rr;
    op_ptr <= p;
    op_mode <= m;
    op_bit <= b;
    op_imm <= k;
    op_addr <= a;
    do begin
      @(posedge mclk);
      n++;
    end while (op_ready !== 1'b1 && n < 20);
    op_valid <= 1'b0;
    #1;
    pulses = {5'h00, break_pulse, sleep_pulse, wdr_pulse};
    busy = 0;
    while (op_ready !== 1'b1 && busy < 20) begin
      @(posedge mclk);
      #1;
      busy++;
    end
    if (op_ready !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
  endtask

  task automatic li(input logic [3:0] r, input logic [7:0] k);
    run(immediate_load_op, r, 4'h0, ptr_x, ptr_plain, 3'h0, k);
  endtask

  task automatic chk_reg(input logic [3:0] i, input logic [7:0] e);
    @(posedge mclk);
    dbg_idx <= i;
    #1;
    cmp8(dbg_data, e);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    cmp8(status_register, STATUS_RESET);
    cmp16(stack_ptr, SP_RESET_DEF);
  endtask

  // set all eight flags in turn, then clear each one alone
  task automatic s_flags();
    exec_op_t st [8] = '{carry_set_op, zero_set_op, negative_set_op,
      overflow_set_op, sign_set_op, half_carry_set_op,
      transfer_flag_set_op, irq_enable_op};
    exec_op_t cl [8] = '{carry_clear_op, zero_clear_op, negative_clear_op,
      overflow_clear_op, sign_clear_op, half_carry_clear_op,
      transfer_flag_clear_op, irq_disable_op};
    sr = STATUS_RESET;
    for (int i = 0; i < 8; i++) begin
      run(st[i]);
      sr[i] = 1'b1;
      cmp8(status_register, sr);
      cmp16(busy[15:0], 16'h0000);
    end
    for (int i = 0; i < 8; i++) begin
      run(cl[i]);
      sr[i] = 1'b0;
      cmp8(status_register, sr);
    end
  endtask

  task automatic s_copy_bits();
    run(carry_set_op);
    sr = 8'h01;
    li(4'h1, 8'h5a);
    li(4'h3, 8'h00);
    run(reg_copy_op, 4'h2, 4'h1);
    cmp16(busy[15:0], 16'h0000);
    chk_reg(4'h2, 8'h5a);
    cmp8(status_register, sr);
    run(bit_to_flag_op, 4'h0, 4'h1, ptr_x, ptr_plain, 3'h3);
    cmp8(status_register, 8'h41);
    run(bit_to_flag_op, 4'h0, 4'h1, ptr_x, ptr_plain, 3'h2);
    cmp8(status_register, sr);
    run(transfer_flag_set_op);
    run(flag_to_bit_op, 4'h3, 4'h0, ptr_x, ptr_plain, 3'h7);
    chk_reg(4'h3, 8'h80);
    cmp8(status_register, 8'h41);
    run(transfer_flag_clear_op);
    run(flag_to_bit_op, 4'h3, 4'h0, ptr_x, ptr_plain, 3'h7);
    chk_reg(4'h3, 8'h00);
  endtask

  task automatic s_io_direct();
    mem_u.io[5] = 8'hff;
    mem_u.mem[16'h0abc] = 8'hc3;
    run(io_bit_clear_op, 4'h0, 4'h0, ptr_x, ptr_plain, 3'h3, 8'h00, 16'h5);
    cmp8(mem_u.io[5], 8'hf7);
    cmp16(busy[15:0], 16'h0000);
    cmp8(status_register, sr);
    run(io_in_op, 4'h4, 4'h0, ptr_x, ptr_plain, 3'h0, 8'h00, 16'h5);
    cmp16(busy[15:0], 16'h0000);
    chk_reg(4'h4, 8'hf7);
    run(io_out_op, 4'h0, 4'h1, ptr_x, ptr_plain, 3'h0, 8'h00, 16'h6);
    cmp8(mem_u.io[6], 8'h5a);
    run(direct_store_op, 4'h0, 4'h1, ptr_x, ptr_plain, 3'h0, 8'h0, 16'h123);
    cmp8(mem_u.mem[16'h0123], 8'h5a);
    cmp16(busy[15:0], 16'h0000);
    run(direct_load_op, 4'h5, 4'h0, ptr_x, ptr_plain, 3'h0, 8'h0, 16'habc);
    cmp16(busy[15:0], 16'h0000);
    chk_reg(4'h5, 8'hc3);
    cmp8(status_register, sr);
  endtask

  // pointers placed at the wrap points of both bytes
  task automatic s_pointers();
    li(4'ha, 8'hff);
    li(4'hb, 8'hff);
    run(indirect_store_op, 4'h0, 4'h1, ptr_x, ptr_post_inc);
    cmp8(mem_u.mem[16'hffff], 8'h5a);
    cmp16(busy[15:0], 16'h0000);
    chk_reg(4'ha, 8'h00);
    chk_reg(4'hb, 8'h00);
    run(indirect_load_op, 4'h6, 4'h0, ptr_x, ptr_pre_dec);
    cmp16(busy[15:0], 16'h0001);
    chk_reg(4'h6, 8'h5a);
    chk_reg(4'hb, 8'hff);
    li(4'he, 8'h00);
    li(4'hf, 8'h03);
    run(indirect_store_op, 4'h0, 4'h4, ptr_z, ptr_pre_dec);
    cmp16(busy[15:0], 16'h0001);
    cmp8(mem_u.mem[16'h02ff], 8'hf7);
    chk_reg(4'hf, 8'h02);
    mem_u.mem[16'h01ff] = 8'h3c;
    li(4'hc, 8'hff);
    li(4'hd, 8'h01);
    run(indirect_load_op, 4'h7, 4'h0, ptr_y, ptr_post_inc);
    cmp16(busy[15:0], 16'h0001);
    chk_reg(4'h7, 8'h3c);
    chk_reg(4'hc, 8'h00);
    chk_reg(4'hd, 8'h02);
    run(indirect_store_op, 4'h0, 4'h5, ptr_y, ptr_plain);
    cmp16(busy[15:0], 16'h0000);
    cmp8(mem_u.mem[16'h0200], 8'hc3);
    chk_reg(4'hc, 8'h00);
    run(indirect_load_op, 4'h8, 4'h0, ptr_z, ptr_plain);
    cmp16(busy[15:0], 16'h0000);
    chk_reg(4'h8, 8'hf7);
    chk_reg(4'he, 8'hff);
    cmp8(status_register, sr);
  endtask

  task automatic s_stack();
    run(push_op, 4'h0, 4'h1);
    cmp16(busy[15:0], 16'h0001);
    run(push_op, 4'h0, 4'h4);
    cmp8(mem_u.mem[16'h00ff], 8'h5a);
    cmp8(mem_u.mem[16'h00fe], 8'hf7);
    cmp16(stack_ptr, 16'h00fd);
    run(pop_op, 4'h9);
    cmp16(busy[15:0], 16'h0001);
    run(pop_op, 4'h5);
    chk_reg(4'h9, 8'hf7);
    chk_reg(4'h5, 8'h5a);
    cmp16(stack_ptr, 16'h00ff);
    cmp8(status_register, sr);
  endtask

  task automatic s_control();
    exec_op_t t [4] = '{break_op, sleep_op, watchdog_restart_op, idle_op};
    logic [7:0] e [4] = '{8'h04, 8'h02, 8'h01, 8'h00};
    for (int i = 0; i < 4; i++) begin
      run(t[i]);
      cmp8(pulses, e[i]);
      cmp16(busy[15:0], 16'h0000);
      cmp8(status_register, sr);
      @(posedge mclk);
      #1;
      cmp8({5'h00, break_pulse, sleep_pulse, wdr_pulse}, 8'h00);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    s_reset();
    s_flags();
    s_copy_bits();
    s_io_direct();
    s_pointers();
    s_stack();
    s_control();
    wrap_up();
  end
endmodule

//--- verilog/bit_flag_transfer_exec.sv
// execution unit for bit, flag, data transfer and core control operations
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Overview of operation
// - io bit clear zeroes one I/O bit in one cycle, flags kept
// - bit store copies a register bit into T in one cycle
// - bit load copies T into a register bit, one cycle, flags kept
// - single ops set or clear one of C, N, Z, H or I
// - single ops set or clear one of S, V or T, other flags kept
// - copy, immediate, I/O in and out take one cycle, no flags
// - load with post-increment reads then bumps pointer, two cycles
// - load with pre-decrement drops pointer then reads, two cycles
// - store plain or post-increment writes in one cycle
// - store with pre-decrement drops pointer then writes, two cycles
// - direct load reads the encoded address in one cycle
// - direct store writes the encoded address in one cycle
// - push writes the register to the stack in two cycles
// - pop reads the stack top into a register in two cycles
// - break, idle, sleep, watchdog restart take one cycle, no flags
// ------------------------------------------------------------------
module bit_flag_transfer_exec #(
  parameter logic [15:0] SP_RESET = exec_pkg::SP_RESET_DEF,
  parameter int IO_AW = exec_pkg::IO_AW_DEF
) (
  input logic mclk,
  input logic rst,
  input logic op_valid,
  output logic op_ready,
  input exec_pkg::exec_op_t op_code,
  input logic [3:0] op_rd,
  input logic [3:0] op_rr,
  input logic [2:0] op_bit,
  input logic [7:0] op_imm,
  input logic [15:0] op_addr,
  input exec_pkg::ptr_sel_t op_ptr,
  input exec_pkg::ptr_mode_t op_mode,
  output logic [15:0] mem_addr,
  output logic mem_re,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  input logic [7:0] mem_rdata,
  output logic [IO_AW-1:0] io_addr,
  output logic io_re,
  output logic io_we,
  output logic [7:0] io_wdata,
  input logic [7:0] io_rdata,
  output logic [7:0] status_register,
  output logic [15:0] stack_ptr,
  output logic break_pulse,
  output logic sleep_pulse,
  output logic wdr_pulse,
  input logic [3:0] dbg_idx,
  output logic [7:0] dbg_data
);
  import exec_pkg::*;

  if (IO_AW < 1 || IO_AW > 16) begin : g_chk
    $error("bit_flag_transfer_exec: IO_AW out of range");
  end

  typedef enum logic {ST_ISSUE, ST_SECOND} exec_state_t;

  // {hit, value, flag index}
  function automatic logic [4:0] flag_op_decode(input exec_op_t op);
    case (op)
      carry_set_op: return {2'b11, FLAG_C};
      carry_clear_op: return {2'b10, FLAG_C};
      negative_set_op: return {2'b11, FLAG_N};
      negative_clear_op: return {2'b10, FLAG_N};
      zero_set_op: return {2'b11, FLAG_Z};
      zero_clear_op: return {2'b10, FLAG_Z};
      irq_enable_op: return {2'b11, FLAG_I};
      irq_disable_op: return {2'b10, FLAG_I};
      sign_set_op: return {2'b11, FLAG_S};
      sign_clear_op: return {2'b10, FLAG_S};
      overflow_set_op: return {2'b11, FLAG_V};
      overflow_clear_op: return {2'b10, FLAG_V};
      transfer_flag_set_op: return {2'b11, FLAG_T};
      transfer_flag_clear_op: return {2'b10, FLAG_T};
      half_carry_set_op: return {2'b11, FLAG_H};
      half_carry_clear_op: return {2'b10, FLAG_H};
      default: return 5'h00;
    endcase
  endfunction

  exec_state_t state_q;
  exec_op_t pend_op_q;
  ptr_mode_t pend_mode_q;
  ptr_sel_t pend_ptr_q;
  logic [3:0] pend_rd_q;
  logic [3:0] pend_rr_q;
  logic [15:0] pend_ptr_val_q;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [15:0] sp_q;
  logic [15:0] sp_d;
  logic go_second;
  logic issue;
  logic [4:0] fdec;
  logic bst_bit;

  rf_port_if rf();

  reg_pair_file #(.NREGS(REG_COUNT)) u_regs (
    .mclk(mclk),
    .rst(rst),
    .rf(rf)
  );

  assign op_ready = (state_q == ST_ISSUE);
  assign issue = op_valid && op_ready;
  assign fdec = flag_op_decode(op_code);
  assign bst_bit = rf.b_data[op_bit];
  assign status_register = status_q;
  assign stack_ptr = sp_q;
  assign rf.dbg_idx = dbg_idx;
  assign dbg_data = rf.dbg_data;
  // index muxes sit outside the decode process, which reads the
  // register file data back, so no false loop through it
  assign rf.a_idx = (state_q == ST_ISSUE) ? op_rd : pend_rd_q;
  assign rf.b_idx = (state_q == ST_ISSUE) ? op_rr : pend_rr_q;
  assign rf.wr_idx = (state_q == ST_ISSUE) ? op_rd : pend_rd_q;
  assign rf.ptr_sel = (state_q == ST_ISSUE) ? op_ptr : pend_ptr_q;

  // ----------------------------------------------------------------
  // operation decode and data path
  // ----------------------------------------------------------------
  always_comb begin
    rf.we_byte = 1'b0;
    rf.we_ptr = 1'b0;
    rf.wr_data = 8'h00;
    rf.wr_ptr = 16'h0000;
    mem_addr = 16'h0000;
    mem_re = 1'b0;
    mem_we = 1'b0;
    mem_wdata = 8'h00;
    io_addr = op_addr[IO_AW-1:0];
    io_re = 1'b0;
    io_we = 1'b0;
    io_wdata = 8'h00;
    status_d = status_q;
    sp_d = sp_q;
    go_second = 1'b0;
    if (issue) begin
      case (op_code)
        io_bit_clear_op: begin
          io_re = 1'b1;
          io_we = 1'b1;
          io_wdata = io_rdata & ~(8'h01 << op_bit);
        end
        bit_to_flag_op: status_d[FLAG_T] = bst_bit;
        flag_to_bit_op: begin
          rf.we_byte = 1'b1;
          rf.wr_data = rf.a_data;
          rf.wr_data[op_bit] = status_q[FLAG_T];
        end
        reg_copy_op: begin
          rf.we_byte = 1'b1;
          rf.wr_data = rf.b_data;
        end
        immediate_load_op: begin
          rf.we_byte = 1'b1;
          rf.wr_data = op_imm;
        end
        io_in_op: begin
          io_re = 1'b1;
          rf.we_byte = 1'b1;
          rf.wr_data = io_rdata;
        end
        io_out_op: begin
          io_we = 1'b1;
          io_wdata = rf.b_data;
        end
        direct_load_op: begin
          mem_re = 1'b1;
          mem_addr = op_addr;
          rf.we_byte = 1'b1;
          rf.wr_data = mem_rdata;
        end
        direct_store_op: begin
          mem_we = 1'b1;
          mem_addr = op_addr;
          mem_wdata = rf.b_data;
        end
        indirect_load_op: begin
          if (op_mode == ptr_pre_dec) begin
            rf.we_ptr = 1'b1;
            rf.wr_ptr = rf.ptr_val - 16'h0001;
            go_second = 1'b1;
          end else begin
            // read now, post-increment takes the next cycle
            mem_re = 1'b1;
            mem_addr = rf.ptr_val;
            rf.we_byte = 1'b1;
            rf.wr_data = mem_rdata;
            go_second = (op_mode == ptr_post_inc);
          end
        end
        indirect_store_op: begin
          if (op_mode == ptr_pre_dec) begin
            rf.we_ptr = 1'b1;
            rf.wr_ptr = rf.ptr_val - 16'h0001;
            go_second = 1'b1;
          end else begin
            // write now, and for post-increment bump pointer in the same cycle
            mem_we = 1'b1;
            mem_addr = rf.ptr_val;
            mem_wdata = rf.b_data;
            rf.we_ptr = (op_mode == ptr_post_inc);
            rf.wr_ptr = rf.ptr_val + 16'h0001;
          end
        end
        push_op: begin
          mem_we = 1'b1;
          mem_addr = sp_q;
          mem_wdata = rf.b_data;
          go_second = 1'b1;
        end
        pop_op: begin
          sp_d = sp_q + 16'h0001;
          go_second = 1'b1;
        end
        default: begin
          if (fdec[4]) begin
            status_d[fdec[2:0]] = fdec[3];
          end
        end
      endcase
    end else if (state_q == ST_SECOND) begin
      case (pend_op_q)
        indirect_load_op: begin
          if (pend_mode_q == ptr_post_inc) begin
            rf.we_ptr = 1'b1;
            rf.wr_ptr = pend_ptr_val_q + 16'h0001;
          end else begin
            mem_re = 1'b1;
            mem_addr = rf.ptr_val;
            rf.we_byte = 1'b1;
            rf.wr_data = mem_rdata;
          end
        end
        indirect_store_op: begin
          mem_we = 1'b1;
          mem_addr = rf.ptr_val;
          mem_wdata = rf.b_data;
        end
        push_op: sp_d = sp_q - 16'h0001;
        pop_op: begin
          mem_re = 1'b1;
          mem_addr = sp_q;
          rf.we_byte = 1'b1;
          rf.wr_data = mem_rdata;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequencing state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_ISSUE;
      pend_op_q <= idle_op;
      pend_mode_q <= ptr_plain;
      pend_ptr_q <= ptr_x;
      pend_rd_q <= 4'h0;
      pend_rr_q <= 4'h0;
      pend_ptr_val_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_ISSUE: begin
          if (go_second) begin
            state_q <= ST_SECOND;
            pend_op_q <= op_code;
            pend_mode_q <= op_mode;
            pend_ptr_q <= op_ptr;
            pend_rd_q <= op_rd;
            pend_rr_q <= op_rr;
            pend_ptr_val_q <= rf.ptr_val;
          end
        end
        ST_SECOND: state_q <= ST_ISSUE;
        default: state_q <= ST_ISSUE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status, stack pointer and control pulses
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_q <= STATUS_RESET;
      sp_q <= SP_RESET;
    end else begin
      status_q <= status_d;
      sp_q <= sp_d;
    end
  end

  // break, sleep and watchdog restart only raise a pulse, idle raises none
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      break_pulse <= 1'b0;
      sleep_pulse <= 1'b0;
      wdr_pulse <= 1'b0;
    end else begin
      break_pulse <= issue && (op_code == break_op);
      sleep_pulse <= issue && (op_code == sleep_op);
      wdr_pulse <= issue && (op_code == watchdog_restart_op);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_io_bit_clear:
    assert property (issue && op_code == io_bit_clear_op |->
      io_we && io_wdata == (io_rdata & ~(8'h01 << op_bit))
      ##1 op_ready && status_q == $past(status_q))
    else $error("io bit clear wrong");
  a_tflag_store:
    assert property (issue && op_code == bit_to_flag_op |=>
      status_q[FLAG_T] == $past(bst_bit) &&
      (status_q & 8'hbf) == ($past(status_q) & 8'hbf))
    else $error("bit store to T wrong");
  a_tflag_load:
    assert property (issue && op_code == flag_to_bit_op |->
      rf.we_byte && rf.wr_data[op_bit] == status_q[FLAG_T]
      ##1 $stable(status_q))
    else $error("T load into register wrong");
  a_carry_set_only:
    assert property (issue && op_code == carry_set_op |=>
      status_q == ($past(status_q) | 8'h01))
    else $error("carry set touched other flags");
  a_overflow_clear_only:
    assert property (issue && op_code == overflow_clear_op |=>
      status_q == ($past(status_q) & 8'hf7))
    else $error("overflow clear touched other flags");
  a_moves_one_cycle:
    assert property (issue && (op_code == reg_copy_op ||
      op_code == immediate_load_op || op_code == io_out_op) |=>
      op_ready && $stable(status_q))
    else $error("move took extra cycle or changed flags");
  a_ld_post_inc:
    assert property (issue && op_code == indirect_load_op &&
      op_mode == ptr_post_inc |-> mem_re ##1 !op_ready && rf.we_ptr &&
      rf.wr_ptr == $past(rf.ptr_val) + 16'h0001 ##1 op_ready)
    else $error("post-increment load sequence wrong");
  a_ld_pre_dec:
    assert property (issue && op_code == indirect_load_op &&
      op_mode == ptr_pre_dec |-> rf.we_ptr && !mem_re
      ##1 mem_re && mem_addr == $past(rf.wr_ptr))
    else $error("pre-decrement load sequence wrong");
  a_st_pre_dec:
    assert property (issue && op_code == indirect_store_op &&
      op_mode == ptr_pre_dec |-> !mem_we
      ##1 mem_we && mem_addr == $past(rf.ptr_val) - 16'h0001)
    else $error("pre-decrement store sequence wrong");
  a_push_stack:
    assert property (issue && op_code == push_op |->
      mem_we && mem_addr == sp_q ##1 !op_ready
      ##1 op_ready && sp_q == $past(sp_q, 2) - 16'h0001)
    else $error("push sequence wrong");
  a_pop_stack:
    assert property (issue && op_code == pop_op |=>
      !op_ready && mem_re && mem_addr == $past(sp_q) + 16'h0001)
    else $error("pop sequence wrong");
  a_idle_no_effect:
    assert property (issue && op_code == idle_op |=>
      op_ready && $stable(status_q) && $stable(sp_q))
    else $error("idle operation had an effect");

  c_push_pop: cover property (issue && op_code == push_op
    ##2 issue && op_code == pop_op);
  c_ld_pre_dec: cover property (issue && op_code == indirect_load_op &&
    op_mode == ptr_pre_dec);
  c_st_post_inc: cover property (issue && op_code == indirect_store_op &&
    op_mode == ptr_post_inc);
endmodule

//--- verilog/exec_pkg.sv
// shared types and constants for the flag and transfer execution unit
package exec_pkg;

  // ----------------------------------------------------------------
  // operations and pointer selection
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    idle_op, io_bit_clear_op, bit_to_flag_op, flag_to_bit_op,
    carry_set_op, carry_clear_op, negative_set_op, negative_clear_op,
    zero_set_op, zero_clear_op, irq_enable_op, irq_disable_op,
    sign_set_op, sign_clear_op, overflow_set_op, overflow_clear_op,
    transfer_flag_set_op, transfer_flag_clear_op,
    half_carry_set_op, half_carry_clear_op,
    reg_copy_op, immediate_load_op, indirect_load_op, direct_load_op,
    indirect_store_op, direct_store_op, io_in_op, io_out_op,
    push_op, pop_op, break_op, sleep_op, watchdog_restart_op
  } exec_op_t;

  typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} ptr_sel_t;
  typedef enum logic [1:0] {ptr_plain, ptr_post_inc, ptr_pre_dec} ptr_mode_t;

  // ----------------------------------------------------------------
  // register file and status layout
  // ----------------------------------------------------------------
  localparam int REG_COUNT = 16;
  localparam logic [3:0] PTR_X_LO = 4'ha;
  localparam logic [3:0] PTR_Y_LO = 4'hc;
  localparam logic [3:0] PTR_Z_LO = 4'he;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] SP_RESET_DEF = 16'h00ff;
  localparam int IO_AW_DEF = 6;

  function automatic logic [3:0] ptr_lo_idx(input ptr_sel_t s);
    case (s)
      ptr_x: return PTR_X_LO;
      ptr_y: return PTR_Y_LO;
      default: return PTR_Z_LO;
    endcase
  endfunction

  function automatic logic [3:0] ptr_hi_idx(input ptr_sel_t s);
    return ptr_lo_idx(s) | 4'h1;
  endfunction

endpackage

//--- verilog/reg_pair_file.sv
// working register file with byte writes and pointer-pair writes
`timescale 1ns/1ps
module reg_pair_file #(
  parameter int NREGS = 16
) (
  input logic mclk,
  input logic rst,
  rf_port_if.store rf
);
  import exec_pkg::*;

  logic [7:0] regs_q [NREGS];

  // pointer pairs sit at fixed indices, so the count cannot move
  if (NREGS != REG_COUNT) begin : g_chk
    $error("reg_pair_file: NREGS must equal REG_COUNT");
  end

  assign rf.a_data = regs_q[rf.a_idx];
  assign rf.b_data = regs_q[rf.b_idx];
  assign rf.dbg_data = regs_q[rf.dbg_idx];
  assign rf.ptr_val = {regs_q[ptr_hi_idx(rf.ptr_sel)],
                       regs_q[ptr_lo_idx(rf.ptr_sel)]};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NREGS; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (rf.we_ptr) begin
      regs_q[ptr_hi_idx(rf.ptr_sel)] <= rf.wr_ptr[15:8];
      regs_q[ptr_lo_idx(rf.ptr_sel)] <= rf.wr_ptr[7:0];
    end else if (rf.we_byte) begin
      regs_q[rf.wr_idx] <= rf.wr_data;
    end
  end
endmodule

//--- verilog/rf_port_if.sv
// ports between the execution control and the working register file
`timescale 1ns/1ps
interface rf_port_if;
  import exec_pkg::*;
  logic [3:0] a_idx;
  logic [3:0] b_idx;
  logic [3:0] dbg_idx;
  logic [3:0] wr_idx;
  logic [7:0] a_data;
  logic [7:0] b_data;
  logic [7:0] dbg_data;
  logic [7:0] wr_data;
  logic we_byte;
  logic we_ptr;
  logic [15:0] wr_ptr;
  logic [15:0] ptr_val;
  ptr_sel_t ptr_sel;

  modport core(
    output a_idx, b_idx, dbg_idx, wr_idx, wr_data, we_byte, we_ptr,
    output wr_ptr, ptr_sel,
    input a_data, b_data, dbg_data, ptr_val
  );
  modport store(
    input a_idx, b_idx, dbg_idx, wr_idx, wr_data, we_byte, we_ptr,
    input wr_ptr, ptr_sel,
    output a_data, b_data, dbg_data, ptr_val
  );
endinterface
